// ### core/fpc_host.sv
// Host-side controller driving an asynchronous dual-bank parallel flash
`timescale 1ns/1ps
`include "fpc_params.svh"

// Function
// R01: Low reset pin puts device in power-down
// R02: Power-down floats data and deselects device
// R03: Hold reset pin low at least 100 ns
// R04: Wake-up returns read array, status 80H
// R05: Wait wake-up interval before reading data
// R06: Reset pin low aborts embedded operations
// R07: Busy indicator low until abort completes
// R08: Wait recovery interval before next command
// R09: Tie flash reset pin to CPU reset
// R10: Identifier mode returns maker, device, block codes
// R11: Block code shows lock and erase state
// R12: Query data appears on low eight lines
// R13: Command write needs write and bank enable
// R14: Capture on first rising edge of enables
// R15: Supply block or location address per command
// R16: Commands select what reads return
// R17: Read drives bank and output enable low
// R18: Output enable high floats data lines
// R19: Never both banks, never read and write
// R20: Deselected device finishes embedded operation
module fpc_host #(
  parameter int SETUP_CYC = 2,
  parameter int PULSE_CYC = 4,
  parameter int HOLD_CYC = 1
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic req_valid, // Request strobe
  input wire fpc_pkg::fpc_req_t req, // Request fields
  output logic req_ready, // Idle and may take a request
  output logic rsp_valid, // Read data valid pulse
  output logic [15:0] rsp_data, // Read data
  output logic query_mode, // Last command selected query reads
  output logic pd_active, // Flash held in power-down
  output logic [20:0] addr, // Flash address
  output logic bank0_select_n, // Bank 0 enable
  output logic bank1_low_select_n, // Bank 1 low enable
  output logic bank1_high_select_n, // Bank 1 high enable
  output logic oe_n, // Output enable
  output logic we_n, // Write enable
  output logic reset_powerdown_n, // Reset and power-down pin
  output logic [15:0] data_lines_o, // Data out
  output logic data_lines_oe, // Data drive enable
  input wire logic [15:0] data_lines_i, // Data in
  input wire logic busy_indicator // Low while embedded op runs
);
  initial begin
    if (SETUP_CYC < 1 || PULSE_CYC < 1 || HOLD_CYC < 1 ||
        SETUP_CYC > 255 || PULSE_CYC > 255 || HOLD_CYC > 255) $error("fpc_host cycle counts");
  end

  localparam int TW = 8;

  typedef enum logic [2:0] {
    ST_BOOT, ST_WAKE, ST_IDLE, ST_SETUP, ST_PULSE, ST_HOLD, ST_PD, ST_PDHOLD
  } fpc_state_t;

  fpc_state_t st_r, st_nxt;
  fpc_pkg::fpc_req_t cur_r, cur_nxt;
  logic [7:0] ph_r, ph_nxt;
  logic cmd_ok_r, cmd_ok_nxt;
  logic [20:0] addr_nxt;
  logic b0_nxt, b1l_nxt, b1h_nxt, oe_nxt, we_nxt, rp_nxt, doe_nxt;
  logic [15:0] dout_nxt, rdata_nxt;
  logic rv_nxt, rdy_nxt, qm_nxt, pda_nxt;
  logic t_load;
  logic [TW-1:0] t_cnt;
  logic t_busy;

  fpc_timer #(.WIDTH(TW)) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .load(t_load),
    .count(t_cnt),
    .busy(t_busy)
  );

  // ---------------------------------------------------------------
  // Bus sequencer
  // ---------------------------------------------------------------
  // Next state and pin values; one bank decoded, never two (R19)
  always_comb begin
    st_nxt = st_r;
    cur_nxt = cur_r;
    ph_nxt = ph_r;
    cmd_ok_nxt = cmd_ok_r;
    addr_nxt = addr;
    b0_nxt = 1'b1;
    b1l_nxt = 1'b1;
    b1h_nxt = 1'b1;
    oe_nxt = 1'b1;
    we_nxt = 1'b1;
    rp_nxt = 1'b1;
    doe_nxt = 1'b0;
    dout_nxt = data_lines_o;
    rdata_nxt = rsp_data;
    rv_nxt = 1'b0;
    rdy_nxt = 1'b0;
    qm_nxt = query_mode;
    pda_nxt = 1'b0;
    t_load = 1'b0;
    t_cnt = '0;
    case (st_r)
      ST_WAKE: begin
        // Recovery spent and any aborted operation has let go of the busy pin
        if (!t_busy && busy_indicator) begin
          st_nxt = ST_IDLE;
          rdy_nxt = 1'b1;
          cmd_ok_nxt = 1'b1; // R08
        end
      end
      ST_IDLE: begin
        rdy_nxt = 1'b1;
        if (req_valid) begin
          cur_nxt = req;
          rdy_nxt = 1'b0;
          addr_nxt = req.addr; // R15
          ph_nxt = 8'(SETUP_CYC);
          if (req.op == fpc_pkg::FPC_OP_PWRDN) begin
            // Drive low; aborts any embedded operation in the flash
            st_nxt = ST_PD; // R01 R06
            rp_nxt = 1'b0;
            pda_nxt = 1'b1;
            t_load = 1'b1;
            t_cnt = TW'(`FPC_PD_LOW_CYC); // R03
          end else if (req.op == fpc_pkg::FPC_OP_WRITE && !cmd_ok_r) begin
            // Command blocked until recovery passes; stay ready
            rdy_nxt = 1'b1; // R08
          end else begin
            st_nxt = ST_SETUP;
          end
        end
      end
      ST_SETUP: begin
        // Address stable before strobes
        if (ph_r > 8'd1) begin
          ph_nxt = ph_r - 8'd1;
        end else begin
          st_nxt = ST_PULSE;
          ph_nxt = 8'(PULSE_CYC);
        end
        {b0_nxt, b1l_nxt, b1h_nxt} = 3'b111;
        if (ph_r == 8'd1) begin
          case (cur_r.bank)
            2'd0: b0_nxt = 1'b0;
            2'd1: b1l_nxt = 1'b0;
            2'd2: b1h_nxt = 1'b0;
            default: {b1l_nxt, b1h_nxt} = 2'b00;
          endcase
          oe_nxt = (cur_r.op != fpc_pkg::FPC_OP_READ); // R17
          we_nxt = (cur_r.op != fpc_pkg::FPC_OP_WRITE); // R13
          doe_nxt = (cur_r.op == fpc_pkg::FPC_OP_WRITE);
          dout_nxt = cur_r.wdata;
        end
      end
      ST_PULSE: begin
        b0_nxt = bank0_select_n;
        b1l_nxt = bank1_low_select_n;
        b1h_nxt = bank1_high_select_n;
        oe_nxt = oe_n;
        doe_nxt = data_lines_oe;
        if (ph_r > 8'd1) begin
          ph_nxt = ph_r - 8'd1;
          we_nxt = we_n;
        end else begin
          // Release write enable first so it alone marks the capture edge
          we_nxt = 1'b1; // R14
          st_nxt = ST_HOLD;
          ph_nxt = 8'(HOLD_CYC);
          if (cur_r.op == fpc_pkg::FPC_OP_READ) begin
            // Query data only on low byte (R12); ids and array full width
            rdata_nxt = query_mode ? {8'h00, data_lines_i[7:0]} : data_lines_i; // R12 R10 R11
            rv_nxt = 1'b1;
            oe_nxt = 1'b1; // R18
          end else if (data_lines_o[7:0] == `FPC_CMD_QUERY) begin
            qm_nxt = 1'b1; // R16
          end else if (data_lines_o[7:0] == `FPC_CMD_READ_ARRAY ||
                       data_lines_o[7:0] == `FPC_CMD_READ_ID) begin
            qm_nxt = 1'b0; // R16
          end
        end
      end
      ST_HOLD: begin
        // Data held past the capture edge, then bank released
        doe_nxt = data_lines_oe;
        if (ph_r > 8'd1) begin
          ph_nxt = ph_r - 8'd1;
          b0_nxt = bank0_select_n;
          b1l_nxt = bank1_low_select_n;
          b1h_nxt = bank1_high_select_n;
        end else begin
          doe_nxt = 1'b0;
          st_nxt = ST_IDLE;
          rdy_nxt = 1'b1;
        end
      end
      ST_BOOT: begin
        // Reset release still owes the pin a full minimum low time
        rp_nxt = 1'b0; // R03
        pda_nxt = 1'b1;
        t_load = 1'b1;
        t_cnt = TW'(`FPC_PD_LOW_CYC); // R03
        st_nxt = ST_PD;
      end
      ST_PD: begin
        rp_nxt = 1'b0;
        pda_nxt = 1'b1;
        // Stay down while user keeps asking for power-down
        if (!t_busy && !(req_valid && req.op == fpc_pkg::FPC_OP_PWRDN)) begin
          st_nxt = ST_PDHOLD;
          rp_nxt = 1'b1;
          pda_nxt = 1'b0;
          cmd_ok_nxt = 1'b0;
          qm_nxt = 1'b0; // R04
          t_load = 1'b1;
          t_cnt = TW'(`FPC_WAKE_OUT_CYC); // R05
        end
      end
      ST_PDHOLD: begin
        // Abort may still be settling; wake-up also waits on the busy pin (R07)
        if (!t_busy) begin
          st_nxt = ST_WAKE;
          t_load = 1'b1;
          t_cnt = TW'(`FPC_WAKE_CMD_CYC); // R08
        end
      end
      default: st_nxt = ST_IDLE;
    endcase
  end

  // Registered pins; reset holds flash in power-down like CPU reset (R09)
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= ST_BOOT;
      cur_r <= '0;
      ph_r <= 8'h00;
      cmd_ok_r <= 1'b0;
      addr <= 21'h000000;
      bank0_select_n <= 1'b1;
      bank1_low_select_n <= 1'b1;
      bank1_high_select_n <= 1'b1;
      oe_n <= 1'b1;
      we_n <= 1'b1;
      reset_powerdown_n <= 1'b0; // R09
      data_lines_o <= 16'h0000;
      data_lines_oe <= 1'b0;
      rsp_data <= 16'h0000;
      rsp_valid <= 1'b0;
      req_ready <= 1'b0;
      query_mode <= 1'b0;
      pd_active <= 1'b1;
    end else begin
      st_r <= st_nxt;
      cur_r <= cur_nxt;
      ph_r <= ph_nxt;
      cmd_ok_r <= cmd_ok_nxt;
      addr <= addr_nxt;
      bank0_select_n <= b0_nxt;
      bank1_low_select_n <= b1l_nxt;
      bank1_high_select_n <= b1h_nxt;
      oe_n <= oe_nxt;
      we_n <= we_nxt;
      reset_powerdown_n <= rp_nxt;
      data_lines_o <= dout_nxt;
      data_lines_oe <= doe_nxt;
      rsp_data <= rdata_nxt;
      rsp_valid <= rv_nxt;
      req_ready <= rdy_nxt;
      query_mode <= qm_nxt;
      pd_active <= pda_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [7:0] pd_low_cnt; // Saturating, so a long hold never wraps
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pd_low_cnt <= 8'h00;
    end else begin
      pd_low_cnt <= reset_powerdown_n ? 8'h00 : pd_low_cnt + {7'h00, pd_low_cnt != 8'hff};
    end
  end

  sequence s_pd_release;
    $rose(reset_powerdown_n);
  endsequence

  a_pd_min_low: assert property (@(posedge mclk) disable iff (!rst_n) // R03
    s_pd_release |-> $past(pd_low_cnt) >= 8'(`FPC_PD_LOW_CYC))
    else $error("power-down pin low too short");
  a_bank_exclusive: assert property (@(posedge mclk) disable iff (!rst_n) // R19
    !(!bank0_select_n && (!bank1_low_select_n || !bank1_high_select_n)))
    else $error("both banks enabled");
  a_oe_we_apart: assert property (@(posedge mclk) disable iff (!rst_n) // R19
    !(!oe_n && !we_n))
    else $error("read and write strobes together");
  a_pd_pins_idle: assert property (@(posedge mclk) disable iff (!rst_n) // R02
    !reset_powerdown_n |-> (oe_n && we_n && !data_lines_oe))
    else $error("bus active in power-down");
  a_wake_no_cmd: assert property (@(posedge mclk) disable iff (!rst_n) // R08
    s_pd_release |-> ##1 (we_n [*8]))
    else $error("command written before recovery");
  a_we_has_bank: assert property (@(posedge mclk) disable iff (!rst_n) // R13
    !we_n |-> (data_lines_oe && !(bank0_select_n && bank1_low_select_n && bank1_high_select_n)))
    else $error("write strobe without bank or data");
  a_we_first_rise: assert property (@(posedge mclk) disable iff (!rst_n) // R14
    $rose(we_n) |-> !(bank0_select_n && bank1_low_select_n && bank1_high_select_n))
    else $error("bank released before write enable");
  a_read_oe: assert property (@(posedge mclk) disable iff (!rst_n) // R17
    rsp_valid |-> $past(!oe_n) && we_n && reset_powerdown_n)
    else $error("read answer without output enable");
  a_query_low: assert property (@(posedge mclk) disable iff (!rst_n) // R12
    (rsp_valid && query_mode) |-> rsp_data[15:8] == 8'h00)
    else $error("query data above low byte");
endmodule : fpc_host

// ### core/fpc_params.svh
// Timing constants and command codes for the flash bus host controller
`ifndef FPC_PARAMS_SVH
`define FPC_PARAMS_SVH
`define FPC_CLK_PERIOD_PS 8000
`define FPC_PD_LOW_MIN_NS 100
`define FPC_PD_LOW_CYC ((`FPC_PD_LOW_MIN_NS * 1000 + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_WAKE_OUT_NS 150
`define FPC_WAKE_OUT_CYC ((`FPC_WAKE_OUT_NS * 1000 + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_WAKE_CMD_NS 100
`define FPC_WAKE_CMD_CYC ((`FPC_WAKE_CMD_NS * 1000 + `FPC_CLK_PERIOD_PS - 1) / `FPC_CLK_PERIOD_PS)
`define FPC_CMD_READ_ARRAY 8'hff
`define FPC_CMD_READ_ID 8'h90
`define FPC_CMD_QUERY 8'h98
`define FPC_QUERY_DATA_W 8
`endif

// ### core/fpc_pkg.sv
// Types shared by the flash bus host controller
package fpc_pkg;
  typedef enum logic [1:0] {
    FPC_OP_READ,
    FPC_OP_WRITE,
    FPC_OP_PWRDN
  } fpc_op_t;

  typedef struct packed {
    fpc_op_t op;
    logic [1:0] bank;
    logic [20:0] addr;
    logic [15:0] wdata;
  } fpc_req_t;
endpackage : fpc_pkg

// ### core/fpc_timer.sv
// Down counter that holds busy high for a loaded number of cycles
`timescale 1ns/1ps
module fpc_timer #(
  parameter int WIDTH = 8
) (
  input wire logic mclk, // System clock
  input wire logic rst_n, // Async reset, active low
  input wire logic load, // Start count
  input wire logic [WIDTH-1:0] count, // Cycles to wait
  output logic busy // High while counting
);
  initial begin
    if (WIDTH < 2) $error("fpc_timer WIDTH too small");
  end

  logic [WIDTH-1:0] cnt_r;
  logic [WIDTH-1:0] cnt_nxt;

  // Next count value
  always_comb begin
    cnt_nxt = cnt_r;
    if (load) begin
      cnt_nxt = count;
    end else if (cnt_r != '0) begin
      cnt_nxt = cnt_r - WIDTH'(1);
    end
  end

  // Counter register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end

  assign busy = (cnt_r != '0);
endmodule : fpc_timer

// ### test/fpc_flash_model.sv
// Behavioural dual-bank flash device seen from its pins
`timescale 1ns/1ps
module fpc_flash_model #(
  parameter logic [15:0] MAKER_CODE = 16'h00a1, // Arbitrary value
  parameter logic [15:0] DEVICE_CODE = 16'h00b2, // Arbitrary value
  parameter int ERASE_NS = 2000
) (
  input wire logic [20:0] addr, // Address
  input wire logic bank0_select_n, // Bank 0 enable
  input wire logic bank1_low_select_n, // Bank 1 low enable
  input wire logic bank1_high_select_n, // Bank 1 high enable
  input wire logic oe_n, // Output enable
  input wire logic we_n, // Write enable
  input wire logic reset_powerdown_n, // Power-down pin
  input wire logic [15:0] data_lines, // Resolved bus
  output logic [15:0] dq_out, // Read data or stale pattern
  output logic dq_en, // Device drives the bus
  output logic busy_indicator // Low while erasing
);
  logic sel;
  logic wr_act;
  logic [7:0] mode = 8'hff;
  logic [7:0] status = 8'h80;
  logic [7:0] prev = 8'h00;
  logic [15:0] rdv;
  logic [15:0] last = 16'h0000;
  logic erasing = 1'b0;
  // Any half of either bank selects the part
  assign sel = ~(bank0_select_n & bank1_low_select_n & bank1_high_select_n);
  assign wr_act = sel & ~we_n & reset_powerdown_n;
  assign dq_en = sel & ~oe_n & we_n & reset_powerdown_n;
  // Released bus shows the inverse of the last word, so stale data never matches
  assign dq_out = dq_en ? rdv : ~last;
  assign busy_indicator = ~erasing;
  // Read source follows the last mode command
  always @* begin
    case (mode)
      8'h90: rdv = addr[1:0] == 2'd0 ? MAKER_CODE : addr[1:0] == 2'd1 ? DEVICE_CODE :
        {14'h0, addr[18], addr[16]};
      8'h98: rdv = {8'h00, 8'h51 + 8'(3 * (addr % 48))};
      8'h70: rdv = {8'h00, status};
      default: rdv = addr[15:0] ^ {addr[20:16], 11'h5a3};
    endcase
  end
  always @(negedge dq_en) last = rdv;
  // Command taken on whichever enable rises first
  always @(negedge wr_act) begin
    if (reset_powerdown_n) begin
      case (data_lines[7:0])
        8'hff, 8'h90, 8'h98, 8'h70: mode = data_lines[7:0];
        8'h50: status = 8'h80;
        8'hd0: erasing = (prev == 8'h20) | erasing;
        default: ;
      endcase
      prev = data_lines[7:0];
    end
  end
  // Wake-up returns to array reads with a clean status
  always @(posedge reset_powerdown_n) begin
    mode = 8'hff;
    status = 8'h80;
  end
  // Erase runs on when deselected; a low pin cuts it short after a brief reset
  always begin
    wait (erasing);
    status = 8'h00;
    fork : run
      #(ERASE_NS);
      @(negedge reset_powerdown_n) #40;
    join_any
    disable run;
    erasing = 1'b0;
    status = 8'h80;
  end
endmodule : fpc_flash_model

// ### test/fpc_host_bench.sv
// Self-checking bench for the flash bus host controller
`timescale 1ns/1ps
`include "fpc_params.svh"
module fpc_host_bench;
  localparam logic [15:0] MAKER = 16'h00a1; // Arbitrary value
  localparam logic [15:0] DEVICE = 16'h00b2; // Arbitrary value
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic req_valid = 1'b0;
  fpc_pkg::fpc_req_t req = '0;
  logic req_ready, rsp_valid, query_mode, pd_active, oe_n, we_n, reset_powerdown_n;
  logic bank0_select_n, bank1_low_select_n, bank1_high_select_n, data_lines_oe;
  logic dq_en, busy_indicator;
  logic [15:0] rsp_data, data_lines_o, dq_out, bus;
  logic [20:0] addr;
  integer fails = 0, samples_checked = 0, seed = 53, cycles = 0, low_cnt = 0, since = 0;
  integer ref_mode = 'hff;
  logic [15:0] exp_q[$];
  always #4 mclk = ~mclk;
  // Host drive wins only while it is enabled
  assign bus = data_lines_oe ? data_lines_o : dq_out;
  fpc_host DUT (.mclk, .rst_n, .req_valid, .req, .req_ready, .rsp_valid, .rsp_data,
    .query_mode, .pd_active, .addr, .bank0_select_n, .bank1_low_select_n,
    .bank1_high_select_n, .oe_n, .we_n, .reset_powerdown_n, .data_lines_o,
    .data_lines_oe, .data_lines_i(bus), .busy_indicator);
  fpc_flash_model #(.MAKER_CODE(MAKER), .DEVICE_CODE(DEVICE)) FLASH (.addr,
    .bank0_select_n, .bank1_low_select_n, .bank1_high_select_n, .oe_n, .we_n,
    .reset_powerdown_n, .data_lines(bus), .dq_out, .dq_en, .busy_indicator);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : close_out
  // Reference read value for the current mode
  function automatic logic [15:0] ref_read(input logic [20:0] a);
    case (ref_mode)
      'h90: return a[1:0] == 0 ? MAKER : a[1:0] == 1 ? DEVICE : {14'h0, a[18], a[16]};
      'h98: return 16'(81 + 3 * (a % 48)) & 16'h00ff;
      'h70: return 16'h0080;
      default: return a[15:0] ^ {a[20:16], 11'h5a3};
    endcase
  endfunction : ref_read
  // One request, offered for one cycle once ready; reads return the answered word
  task automatic do_req(input fpc_pkg::fpc_op_t op, input logic [1:0] bank,
    input logic [20:0] a, input logic [15:0] wd, output logic [15:0] d);
    integer n;
    n = 0;
    while (req_ready !== 1'b1 && n < 400) begin
      @(posedge mclk);
      #1;
      n++;
    end
    req = '{op, bank, a, wd};
    req_valid = 1'b1;
    @(posedge mclk);
    #1;
    req_valid = 1'b0;
    if (op == fpc_pkg::FPC_OP_WRITE && wd[7:0] inside {8'hff, 8'h90, 8'h98, 8'h70})
      ref_mode = wd[7:0];
    if (op == fpc_pkg::FPC_OP_PWRDN)
      ref_mode = 'hff;
    if (op == fpc_pkg::FPC_OP_READ) begin
      exp_q.push_back(ref_read(a));
      n = 0;
      while (rsp_valid !== 1'b1 && n < 20) begin
        @(posedge mclk);
        #1;
        n++;
      end
      d = rsp_data;
    end
  endtask : do_req
  // Pin-level watch over every cycle
  always @(negedge mclk) begin
    low_cnt = reset_powerdown_n === 1'b0 ? low_cnt + 1 : low_cnt;
    if (reset_powerdown_n === 1'b1 && low_cnt > 0) begin
      check("pd_len", low_cnt >= `FPC_PD_LOW_CYC, 1'b1);
      low_cnt = 0;
    end
    since = reset_powerdown_n === 1'b1 ? since + 1 : 0;
    if (rst_n === 1'b1) begin
      check("two_banks", !bank0_select_n && !(bank1_low_select_n && bank1_high_select_n), 0);
      check("oe_we", !oe_n && !we_n, 1'b0);
      check("fight", data_lines_oe && dq_en, 1'b0);
      if (reset_powerdown_n === 1'b0) check("pd_float", data_lines_oe, 1'b0);
      if (oe_n === 1'b0) check("wake_rd", since >= `FPC_WAKE_OUT_CYC, 1'b1);
      if (we_n === 1'b0) check("wake_wr", since >= `FPC_WAKE_CMD_CYC, 1'b1);
    end
  end
  // Hang guard well beyond the expected run
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 3000) begin
      fails++;
      close_out();
    end
  end
  initial begin
    logic [20:0] a;
    logic [15:0] d;
    integer i;
    repeat (20) @(posedge mclk);
    #1;
    rst_n = 1'b1;
    for (i = 0; i < 6; i++) begin
      a = 21'($random(seed));
      do_req(fpc_pkg::FPC_OP_READ, 2'(i % 4), a, 16'h0000, d);
      check("array", d, exp_q.pop_front());
    end
    check("pd_idle", pd_active, 1'b0);
    $display("test array done");
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd1, 21'($random(seed)), 16'h0090, d);
    for (i = 0; i < 4; i++) begin
      a = {5'($random(seed)), 14'h0, 2'(i)};
      do_req(fpc_pkg::FPC_OP_READ, 2'd1, a, 16'h0000, d);
      check("ident", d, exp_q.pop_front());
    end
    $display("test ident done");
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd2, 21'($random(seed)), 16'h0098, d);
    for (i = 0; i < 4; i++) begin
      do_req(fpc_pkg::FPC_OP_READ, 2'd0, 21'($random(seed)), 16'h0000, d);
      check("query", d, exp_q.pop_front());
      check("query_mode", query_mode, 1'b1);
    end
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd0, 21'h000000, 16'h00ff, d);
    repeat (8) @(posedge mclk);
    #1;
    check("query_off", query_mode, 1'b0);
    $display("test query done");
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd0, 21'h030000, 16'h0020, d);
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd0, 21'h030000, 16'h00d0, d);
    repeat (12) @(posedge mclk);
    #1;
    check("busy_run", busy_indicator, 1'b0);
    do_req(fpc_pkg::FPC_OP_PWRDN, 2'd0, 21'h000000, 16'h0000, d);
    check("pd_on", {pd_active, reset_powerdown_n}, 2'b10);
    do_req(fpc_pkg::FPC_OP_WRITE, 2'd3, 21'h000000, 16'h0070, d);
    check("busy_done", busy_indicator, 1'b1);
    do_req(fpc_pkg::FPC_OP_READ, 2'd0, 21'h000000, 16'h0000, d);
    check("status", d, exp_q.pop_front());
    $display("test powerdown done");
    close_out();
  end
endmodule : fpc_host_bench
